/* File: cmc_pkg.sv */
// Constants for the converter miscellaneous configuration register logic
//------------------------------------------------------------------------------
// Behaviour
// (R01) With restore_setpoint_on_stop set, any stop event (shutdown fault, restart fault, controlled stop, low input) reloads the setpoint default.
// (R02) margin_low_restore_sel picks the margin-low restore value: 0 gives fff7h, 1 gives fff1h.
// (R03) margin_high_restore_sel picks the margin-high restore value: 0 gives 0009h, 1 gives 000fh.
// (R04) The options register sits at command F0h and is saved to nonvolatile memory on a store-all command.
// (R05) An overvoltage fault latches the low-side switch on unless the fault action is ignore.
// (R06) With release policy 0 the low-side switch stays on until a new startup or a fault clear while disabled.
// (R07) With release policy 1 the low-side switch releases once feedback falls below 0.2 V.
// (R08) The overcurrent trim field gives 00 none, 01 +12.5%, 10 -25%, 11 -12.5%.
// (R09) The host sets the level-shift enable when it wants ramp overshoot suppressed.
// (R10) The level-shift enable is captured when switching starts and held while switching.
// (R11) Forced clock-output drives the free-running clock onto the lock pin.
// (R12) Forced clock-input makes switching follow the external clock on the lock pin.
// (R13) The lock-fault mask suppresses both status report and response to a lock fault.
// (R14) Reserved bits read zero and ignore writes; reset value is 0013h.
//------------------------------------------------------------------------------
package cmc_pkg;
	localparam logic [7:0]  CMD_MISC_OPTIONS  = 8'hF0;
	localparam logic [15:0] MISC_RESET        = 16'h0013;
	localparam logic [15:0] MISC_WMASK        = 16'h01D7;
	localparam int          B_OV_POLICY       = 0;
	localparam int          B_TRIM_LO         = 1;
	localparam int          B_TRIM_HI         = 2;
	localparam int          B_LVL_SHIFT       = 4;
	localparam int          B_SYNC_OUT        = 6;
	localparam int          B_SYNC_IN         = 7;
	localparam int          B_LOCK_MASK       = 8;
	localparam logic [15:0] MLO_RESTORE_0     = 16'hFFF7;
	localparam logic [15:0] MLO_RESTORE_1     = 16'hFFF1;
	localparam logic [15:0] MHI_RESTORE_0     = 16'h0009;
	localparam logic [15:0] MHI_RESTORE_1     = 16'h000F;
	localparam logic [2:0]  OV_ACTION_IGNORE  = 3'h0;
	localparam logic [1:0]  TRIM_NONE         = 2'h0;
	localparam logic [1:0]  TRIM_PLUS_12P5    = 2'h1;
	localparam logic [1:0]  TRIM_MINUS_25     = 2'h2;
	localparam logic [1:0]  TRIM_MINUS_12P5   = 2'h3;
	typedef enum logic [2:0] {
		CMC_OC_NOMINAL,
		CMC_OC_PLUS_12P5,
		CMC_OC_MINUS_25,
		CMC_OC_MINUS_12P5
	} cmc_oc_t;
	typedef enum {
		CMC_LS_IDLE,
		CMC_LS_LATCHED
	} cmc_ls_state_t;
endpackage

/* File: cmc_misc_config.sv */
// Miscellaneous configuration register and the behaviour it steers
`timescale 1ns/1ns
module cmc_misc_config
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Command register access
	input  wire logic [7:0]  cmd_code,
	input  wire logic        cmd_wr,
	input  wire logic [15:0] cmd_wdata,
	output logic [15:0]      cmd_rdata,
	input  wire logic        store_default_all,
	input  wire logic        nv_load,
	input  wire logic [15:0] nv_rdata,
	output logic             nv_wr,
	output logic [15:0]      nv_wdata,
	// Other configuration bits
	input  wire logic        restore_setpoint_on_stop,
	input  wire logic        margin_low_restore_sel,
	input  wire logic        margin_high_restore_sel,
	// Stop events
	input  wire logic        stop_fault_shutdown,
	input  wire logic        stop_fault_restart,
	input  wire logic        stop_controlled,
	input  wire logic        stop_low_vin,
	output logic             setpoint_reload,
	output logic [15:0]      margin_low_restore,
	output logic [15:0]      margin_high_restore,
	// Overvoltage low-side control
	input  wire logic        ov_fault,
	input  wire logic [2:0]  overvoltage_fault_action,
	input  wire logic        startup_begin,
	input  wire logic        clear_faults,
	input  wire logic        state_disabled,
	input  wire logic        feedback_below_0p2,
	output logic             low_side_on,
	// Overcurrent trim and level shift
	output logic [2:0]       high_side_overcurrent_limit,
	input  wire logic        switching_enable,
	output logic             comp_level_shift_active,
	// Frequency-lock pin
	input  wire logic        free_clk,
	input  wire logic        lock_pin_in,
	input  wire logic        lock_fault,
	output logic             lock_pin_out,
	output logic             lock_pin_oe,
	output logic             pwm_clk_sel_ext,
	output logic             lock_fault_status,
	output logic             lock_fault_response
);
	// ---------------------------------------------------------------------
	// Options register
	// ---------------------------------------------------------------------
	logic [15:0] misc_options_ff, nxt_misc_options;
	logic        nv_wr_ff, nxt_nv_wr;
	logic [15:0] rdata_ff, nxt_rdata;

	always_comb
	begin
		nxt_misc_options = misc_options_ff;
		if (nv_load)
			nxt_misc_options = nv_rdata & cmc_pkg::MISC_WMASK;
		if (cmd_wr && cmd_code == cmc_pkg::CMD_MISC_OPTIONS)
			nxt_misc_options = cmd_wdata & cmc_pkg::MISC_WMASK; // [R04] [R14]
		nxt_nv_wr = store_default_all; // [R04]
		nxt_rdata = (cmd_code == cmc_pkg::CMD_MISC_OPTIONS) ? misc_options_ff : 16'h0000;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			misc_options_ff <= cmc_pkg::MISC_RESET; // [R14]
			nv_wr_ff        <= 1'b0;
			rdata_ff        <= 16'h0000;
		end
		else
		begin
			misc_options_ff <= nxt_misc_options;
			nv_wr_ff        <= nxt_nv_wr;
			rdata_ff        <= nxt_rdata;
		end
	end

	// ---------------------------------------------------------------------
	// Restore values and low-side latch
	// ---------------------------------------------------------------------
	cmc_pkg::cmc_ls_state_t ls_state_ff, nxt_ls_state;
	logic        reload_ff, nxt_reload;
	logic [15:0] mlo_ff, nxt_mlo;
	logic [15:0] mhi_ff, nxt_mhi;
	logic        ov_trip;
	logic        ls_on_ff, nxt_ls_on;

	always_comb
	begin
		ov_trip    = ov_fault && overvoltage_fault_action != cmc_pkg::OV_ACTION_IGNORE;
		nxt_reload = restore_setpoint_on_stop && (stop_fault_shutdown || stop_fault_restart
			|| stop_controlled || stop_low_vin); // [R01]
		nxt_mlo = margin_low_restore_sel ? cmc_pkg::MLO_RESTORE_1
			: cmc_pkg::MLO_RESTORE_0; // [R02]
		nxt_mhi = margin_high_restore_sel ? cmc_pkg::MHI_RESTORE_1
			: cmc_pkg::MHI_RESTORE_0; // [R03]
		nxt_ls_state = ls_state_ff;
		case (ls_state_ff)
			cmc_pkg::CMC_LS_IDLE:
				if (ov_trip)
					nxt_ls_state = cmc_pkg::CMC_LS_LATCHED; // [R05]
			cmc_pkg::CMC_LS_LATCHED:
				if (ov_trip)
					nxt_ls_state = cmc_pkg::CMC_LS_LATCHED;
				else if (misc_options_ff[cmc_pkg::B_OV_POLICY])
				begin
					if (feedback_below_0p2)
						nxt_ls_state = cmc_pkg::CMC_LS_IDLE; // [R07]
				end
				else if (startup_begin || (clear_faults && state_disabled))
					nxt_ls_state = cmc_pkg::CMC_LS_IDLE; // [R06]
			default:
				nxt_ls_state = cmc_pkg::CMC_LS_IDLE;
		endcase
		nxt_ls_on = (nxt_ls_state == cmc_pkg::CMC_LS_LATCHED); // [R05]
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ls_state_ff <= cmc_pkg::CMC_LS_IDLE;
			ls_on_ff    <= 1'b0;
			reload_ff   <= 1'b0;
			mlo_ff      <= cmc_pkg::MLO_RESTORE_0;
			mhi_ff      <= cmc_pkg::MHI_RESTORE_0;
		end
		else
		begin
			ls_state_ff <= nxt_ls_state;
			ls_on_ff    <= nxt_ls_on;
			reload_ff   <= nxt_reload;
			mlo_ff      <= nxt_mlo;
			mhi_ff      <= nxt_mhi;
		end
	end

	// ---------------------------------------------------------------------
	// Trim, level shift and lock pin
	// ---------------------------------------------------------------------
	logic [2:0] oc_ff, nxt_oc;
	logic       lvl_ff, nxt_lvl;
	logic       sw_en_ff, nxt_sw_en;
	logic       pin_out_ff, nxt_pin_out;
	logic       pin_oe_ff, nxt_pin_oe;
	logic       ext_ff, nxt_ext;
	logic       lf_stat_ff, nxt_lf_stat;
	logic       lf_resp_ff, nxt_lf_resp;
	logic       lock_masked;

	always_comb
	begin
		case (misc_options_ff[cmc_pkg::B_TRIM_HI:cmc_pkg::B_TRIM_LO]) // [R08]
			cmc_pkg::TRIM_NONE:       nxt_oc = cmc_pkg::CMC_OC_NOMINAL;
			cmc_pkg::TRIM_PLUS_12P5:  nxt_oc = cmc_pkg::CMC_OC_PLUS_12P5;
			cmc_pkg::TRIM_MINUS_25:   nxt_oc = cmc_pkg::CMC_OC_MINUS_25;
			cmc_pkg::TRIM_MINUS_12P5: nxt_oc = cmc_pkg::CMC_OC_MINUS_12P5;
			default:                  nxt_oc = cmc_pkg::CMC_OC_NOMINAL;
		endcase
		nxt_lvl = lvl_ff;
		if (switching_enable && !sw_en_ff)
			nxt_lvl = misc_options_ff[cmc_pkg::B_LVL_SHIFT]; // [R10]
		else if (!switching_enable)
			nxt_lvl = 1'b0;
		nxt_sw_en   = switching_enable;
		nxt_pin_oe  = misc_options_ff[cmc_pkg::B_SYNC_OUT]; // [R11]
		nxt_pin_out = misc_options_ff[cmc_pkg::B_SYNC_OUT] & free_clk; // [R11]
		nxt_ext     = misc_options_ff[cmc_pkg::B_SYNC_IN] & lock_pin_in; // [R12]
		lock_masked = misc_options_ff[cmc_pkg::B_LOCK_MASK];
		nxt_lf_stat = lock_fault & !lock_masked; // [R13]
		nxt_lf_resp = lock_fault & !lock_masked; // [R13]
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			oc_ff      <= cmc_pkg::CMC_OC_NOMINAL;
			lvl_ff     <= 1'b0;
			sw_en_ff   <= 1'b0;
			pin_out_ff <= 1'b0;
			pin_oe_ff  <= 1'b0;
			ext_ff     <= 1'b0;
			lf_stat_ff <= 1'b0;
			lf_resp_ff <= 1'b0;
		end
		else
		begin
			oc_ff      <= nxt_oc;
			lvl_ff     <= nxt_lvl;
			sw_en_ff   <= nxt_sw_en;
			pin_out_ff <= nxt_pin_out;
			pin_oe_ff  <= nxt_pin_oe;
			ext_ff     <= nxt_ext;
			lf_stat_ff <= nxt_lf_stat;
			lf_resp_ff <= nxt_lf_resp;
		end
	end

	assign cmd_rdata                   = rdata_ff;
	assign nv_wr                       = nv_wr_ff;
	assign nv_wdata                    = misc_options_ff;
	assign setpoint_reload             = reload_ff;
	assign margin_low_restore          = mlo_ff;
	assign margin_high_restore         = mhi_ff;
	assign low_side_on                 = ls_on_ff;
	assign high_side_overcurrent_limit = oc_ff;
	assign comp_level_shift_active     = lvl_ff;
	assign lock_pin_out                = pin_out_ff;
	assign lock_pin_oe                 = pin_oe_ff;
	assign pwm_clk_sel_ext             = ext_ff;
	assign lock_fault_status           = lf_stat_ff;
	assign lock_fault_response         = lf_resp_ff;
endmodule

/* File: cmc_misc_config_asserts.sv */
// Concurrent checks on the ports of the miscellaneous configuration logic
`timescale 1ns/1ns
module cmc_misc_config_asserts
(
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// Register and store
	input wire logic        store_default_all,
	input wire logic        nv_wr,
	input wire logic [15:0] nv_wdata,
	// Setpoint restore
	input wire logic        restore_setpoint_on_stop,
	input wire logic        stop_controlled,
	input wire logic        setpoint_reload,
	// Low side and trim
	input wire logic        ov_fault,
	input wire logic [2:0]  overvoltage_fault_action,
	input wire logic        feedback_below_0p2,
	input wire logic        low_side_on,
	input wire logic [2:0]  high_side_overcurrent_limit,
	// Lock pin
	input wire logic        lock_fault,
	input wire logic        lock_fault_status,
	input wire logic        lock_pin_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	chk_stop_reload: assert property (restore_setpoint_on_stop && stop_controlled |=> setpoint_reload)
		else $error("setpoint reload missing after stop");
	chk_store_save: assert property (store_default_all |=> nv_wr)
		else $error("save request missing after store");
	chk_ov_latch: assert property (ov_fault && overvoltage_fault_action != 3'h0 |=> low_side_on)
		else $error("low side not latched on overvoltage");
	chk_policy_release: assert property (low_side_on && nv_wdata[0] && feedback_below_0p2 && !ov_fault
		|=> !low_side_on)
		else $error("low side not released below threshold");
	chk_trim_code: assert property (!$past(rst) |-> high_side_overcurrent_limit == {1'b0, $past(nv_wdata[2:1])})
		else $error("overcurrent limit code wrong");
	chk_clock_out: assert property (!$past(rst) |-> lock_pin_oe == $past(nv_wdata[6]))
		else $error("lock pin enable wrong");
	chk_lock_mask: assert property (lock_fault && nv_wdata[8] |=> !lock_fault_status)
		else $error("masked lock fault reported");
	chk_reserved_zero: assert property ((nv_wdata & ~16'h01D7) == 16'h0000)
		else $error("reserved bits set");
endmodule
bind cmc_misc_config cmc_misc_config_asserts u_chk (.clk(clk), .rst(rst),
	.store_default_all(store_default_all), .nv_wr(nv_wr), .nv_wdata(nv_wdata),
	.restore_setpoint_on_stop(restore_setpoint_on_stop), .stop_controlled(stop_controlled),
	.setpoint_reload(setpoint_reload), .ov_fault(ov_fault), .low_side_on(low_side_on),
	.overvoltage_fault_action(overvoltage_fault_action), .lock_pin_oe(lock_pin_oe),
	.feedback_below_0p2(feedback_below_0p2), .lock_fault(lock_fault),
	.high_side_overcurrent_limit(high_side_overcurrent_limit), .lock_fault_status(lock_fault_status));

/* File: cmc_host.sv */
// Host model issuing command writes, reads and store requests
`timescale 1ns/1ns
module cmc_host
(
	// Clock
	input wire logic  clk,
	// Command side
	output logic [7:0]  cmd_code,
	output logic        cmd_wr,
	output logic [15:0] cmd_wdata,
	output logic        store_default_all,
	input wire logic [15:0] cmd_rdata
);
	initial {cmd_code, cmd_wr, cmd_wdata, store_default_all} = '0;
	task automatic wr(input logic [15:0] d);
		@(negedge clk);
		{cmd_code, cmd_wr, cmd_wdata} = {8'hF0, 1'b1, d};
		@(negedge clk);
		cmd_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] c, output logic [15:0] d);
		@(negedge clk);
		cmd_code = c;
		@(negedge clk);
		d = cmd_rdata;
	endtask
	task automatic st();
		@(negedge clk);
		store_default_all = 1'b1;
		@(negedge clk);
		store_default_all = 1'b0;
	endtask
endmodule

/* File: testbench.sv */
// Self-checking bench for the miscellaneous configuration logic
`timescale 1ns/1ns
module testbench;
	logic        clk = 1'b0, rst = 1'b1, cmd_wr, store_default_all, nv_load, nv_wr, lock_pin_out;
	logic [7:0]  cmd_code;
	logic [15:0] cmd_wdata, cmd_rdata, nv_rdata, nv_wdata, margin_low_restore, margin_high_restore, d;
	logic [2:0]  overvoltage_fault_action, high_side_overcurrent_limit;
	logic [3:0]  stp;
	logic restore_setpoint_on_stop, margin_low_restore_sel, margin_high_restore_sel, setpoint_reload;
	logic ov_fault, startup_begin, clear_faults, state_disabled, feedback_below_0p2, low_side_on;
	logic switching_enable, comp_level_shift_active, free_clk, lock_pin_in, lock_fault, lock_pin_oe;
	logic pwm_clk_sel_ext, lock_fault_status, lock_fault_response;
	int   num_errors = 0, n_checks = 0, cyc = 0;
	wire  stop_fault_shutdown = stp[0], stop_fault_restart = stp[1];
	wire  stop_controlled = stp[2], stop_low_vin = stp[3];
	cmc_misc_config uut (.*);
	cmc_host host (.clk(clk), .cmd_code(cmd_code), .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata),
		.store_default_all(store_default_all), .cmd_rdata(cmd_rdata));
	always #25 clk = ~clk;
	always @(posedge clk) if (++cyc == 2000) begin num_errors++; close_out(); end
	task automatic chk(input string nm, input logic [15:0] e, g);
		n_checks++;
		if (g !== e) begin num_errors++; $display("ERROR %s expected %h seen %h", nm, e, g); end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		{nv_load, nv_rdata, restore_setpoint_on_stop, margin_low_restore_sel, stp} = '0;
		{margin_high_restore_sel, ov_fault, overvoltage_fault_action, startup_begin} = '0;
		{clear_faults, state_disabled, feedback_below_0p2, switching_enable} = '0;
		{free_clk, lock_pin_in, lock_fault} = '0;
		repeat (6) @(negedge clk);
		rst = 1'b0;
		host.rd(8'hF0, d); chk("options", 16'h0013, d);
		chk("margin_low", 16'hFFF7, margin_low_restore);
		chk("margin_high", 16'h0009, margin_high_restore);
		host.wr(16'hFFFF); host.rd(8'hF0, d); chk("options", 16'h01D7, d);
		host.rd(8'hD6, d); chk("unmapped", 16'h0000, d);
		for (int t = 0; t < 4; t++)
		begin
			host.wr(16'(t << 1)); @(negedge clk);
			chk("trim", 16'(t), {13'h0, high_side_overcurrent_limit});
		end
		host.wr(16'h0145); host.st(); chk("nv_wr", 16'h0001, {15'h0, nv_wr});
		chk("nv_wdata", 16'h0145, nv_wdata);
		chk("clock_oe", 16'h0001, {15'h0, lock_pin_oe});
		{margin_low_restore_sel, margin_high_restore_sel, restore_setpoint_on_stop} = 3'h7;
		@(negedge clk); chk("margin_low", 16'hFFF1, margin_low_restore);
		chk("margin_high", 16'h000F, margin_high_restore);
		for (int i = 0; i < 4; i++)
		begin
			stp = 4'(1 << i); @(negedge clk); chk("reload", 16'h0001, {15'h0, setpoint_reload});
		end
		restore_setpoint_on_stop = 1'b0; stp = 4'hF; @(negedge clk);
		stp = 4'h0; chk("reload", 16'h0000, {15'h0, setpoint_reload});
		$display("test register_restore done");
		ov_fault = 1'b1; @(negedge clk); chk("low_side", 16'h0000, {15'h0, low_side_on});
		overvoltage_fault_action = 3'h1; @(negedge clk); ov_fault = 1'b0;
		chk("low_side", 16'h0001, {15'h0, low_side_on});
		feedback_below_0p2 = 1'b1; @(negedge clk); chk("low_side", 16'h0000, {15'h0, low_side_on});
		host.wr(16'h0000); ov_fault = 1'b1; @(negedge clk); ov_fault = 1'b0; clear_faults = 1'b1;
		@(negedge clk); chk("low_side", 16'h0001, {15'h0, low_side_on});
		state_disabled = 1'b1; @(negedge clk); chk("low_side", 16'h0000, {15'h0, low_side_on});
		{clear_faults, state_disabled} = 2'h0;
		ov_fault = 1'b1; @(negedge clk); ov_fault = 1'b0;
		chk("low_side", 16'h0001, {15'h0, low_side_on});
		startup_begin = 1'b1; @(negedge clk);
		startup_begin = 1'b0; chk("low_side", 16'h0000, {15'h0, low_side_on});
		$display("test low_side done");
		lock_pin_in = 1'b1; lock_fault = 1'b1; host.wr(16'h0180); @(negedge clk);
		chk("ext_clock", 16'h0001, {15'h0, pwm_clk_sel_ext});
		chk("lock_fault", 16'h0000, {14'h0, lock_fault_status, lock_fault_response});
		host.wr(16'h0010); switching_enable = 1'b1; @(negedge clk); @(negedge clk);
		chk("lock_fault", 16'h0003, {14'h0, lock_fault_status, lock_fault_response});
		chk("level_shift", 16'h0001, {15'h0, comp_level_shift_active});
		host.wr(16'h0000); @(negedge clk); chk("level_shift", 16'h0001, {15'h0, comp_level_shift_active});
		free_clk = 1'b1; @(negedge clk);
		chk("clock_out", 16'h0000, {15'h0, lock_pin_out});
		host.wr(16'h0040); @(negedge clk);
		chk("clock_out", 16'h0001, {15'h0, lock_pin_out});
		free_clk = 1'b0; @(negedge clk);
		chk("clock_out", 16'h0000, {15'h0, lock_pin_out});
		nv_rdata = 16'hFFFF; nv_load = 1'b1; @(negedge clk); nv_load = 1'b0;
		host.rd(8'hF0, d); chk("nv_load", 16'h01D7, d);
		$display("test lock_and_shift done");
		close_out();
	end
endmodule
